// ---- ccwb_regs.vh ----
// Register numbers, field positions, reset values and sizes of the cache and write queue block.
`ifndef CCWB_REGS_VH
`define CCWB_REGS_VH

// Register numbers on the plain register port.
`define CCWB_REG_CTRL 3'h1
`define CCWB_REG_STAT 3'h2
`define CCWB_REG_FLUSH 3'h7

// Control register bit positions and reset value.
`define CCWB_CTRL_MMU 0
`define CCWB_CTRL_CACHE 2
`define CCWB_CTRL_WBUF 3
`define CCWB_CTRL_W 4
`define CCWB_CTRL_RST 4'h0

// Status register field positions.
`define CCWB_ST_EMPTY 0
`define CCWB_ST_MEMORY_CLOCK_INPUT 1
`define CCWB_ST_LOCK 2
`define CCWB_ST_SYNC 3
`define CCWB_ST_DCNT_LO 4
`define CCWB_ST_DCNT_HI 7
`define CCWB_ST_ACNT_LO 8
`define CCWB_ST_ACNT_HI 10

// Virtual address split: tag, set index and word within a 16-byte line.
`define CCWB_TAG_HI 31
`define CCWB_TAG_LO 10
`define CCWB_SET_HI 9
`define CCWB_SET_LO 4
`define CCWB_WRD_HI 3
`define CCWB_WRD_LO 2

// Cache geometry: 64 sets of 4 ways, 4 words a line.
`define CCWB_LINES 256
`define CCWB_WORDS 1024
`define CCWB_WAYS 4
`define CCWB_LINE_LAST 2'h3

// Posted write queue capacity.
`define CCWB_WQ_WORDS 4'h8
`define CCWB_WQ_ADDRS 3'h4

// Replacement generator seed.
`define CCWB_LFSR_SEED 8'hA5

`endif

// ---- ccwb_top.v ----
// Unified cache, posted write queue and core clock switching for the processor core.
`timescale 1ns/1ps
`include "ccwb_regs.vh"
`default_nettype none

module ccwb_top (
    // Clock, synchronous reset and clock enable.
    input wire mclk_in,
    input wire resetn_in,
    input wire ce_in,
    // Clock pins from outside this clock's domain.
    input wire sync_async_select_in,
    input wire memory_clock_input_in,
    input wire core_clock_input_in,
    // Register port.
    input wire [2:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [31:0] reg_rdata_out,
    // Core request side.
    input wire core_req_in,
    input wire core_wr_in,
    input wire core_lock_in,
    input wire core_seq_in,
    input wire core_cacheable_in,
    input wire core_bufferable_in,
    input wire [31:0] core_addr_in,
    input wire [31:0] core_wdata_in,
    output reg core_ack_out,
    output reg [31:0] core_rdata_out,
    output reg core_on_mem_clk_out,
    // External memory bus side.
    output reg ext_req_out,
    output reg ext_wr_out,
    output reg ext_lock_out,
    output reg [31:0] ext_addr_out,
    output reg [31:0] ext_wdata_out,
    input wire ext_ack_in,
    input wire [31:0] ext_rdata_in
);

    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_TOMEM = 2'h1;
    localparam [1:0] S_EXT = 2'h2;
    localparam [1:0] S_TOFAST = 2'h3;
    localparam [1:0] OP_SINGLE = 2'h0;
    localparam [1:0] OP_FILL = 2'h1;
    localparam [1:0] OP_UNBUF = 2'h2;

    reg [2:0] ps1_q, ps2_q, ps3_q, pin_q, pin_prev_q;
    reg div_q;
    reg [3:0] ctrl_q;
    reg [7:0] lfsr_q;
    reg [1:0] state_q, op_q, fill_cnt_q, victim_q;
    reg fill_ok_q, lock_q, own_q;
    reg [`CCWB_LINES-1:0] valid_q;
    reg [21:0] tag_q [0:`CCWB_LINES-1];
    reg [31:0] data_q [0:`CCWB_WORDS-1];
    reg [31:0] wq_addr_q [0:3];
    reg [3:0] wq_len_q [0:3];
    reg [31:0] wq_data_q [0:7];
    reg [1:0] wq_ahead_q, wq_atail_q;
    reg [2:0] wq_dhead_q, wq_dtail_q, wq_idx_q;
    reg [3:0] wq_dcnt_q;
    reg [2:0] wq_acnt_q;

    // Pin filter: a level is taken once stages two and three agree, so a
    // single noisy sample never produces a clock edge.
    wire [2:0] pin_raw = {core_clock_input_in, memory_clock_input_in, sync_async_select_in};
    wire [2:0] pin_agree = ~(ps2_q ^ ps3_q);
    wire [2:0] pin_rise = pin_q & ~pin_prev_q;
    wire sync_mode = pin_q[0];

    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            ps1_q <= 3'h0;
            ps2_q <= 3'h0;
            ps3_q <= 3'h0;
            pin_q <= 3'h0;
            pin_prev_q <= 3'h0;
            div_q <= 1'b0;
        end else if (ce_in) begin
            ps1_q <= pin_raw;
            ps2_q <= ps1_q;
            ps3_q <= ps2_q;
            pin_q <= (pin_q & ~pin_agree) | (ps3_q & pin_agree);
            pin_prev_q <= pin_q;
            if (pin_rise[1]) begin
                div_q <= ~div_q;
            end
        end
    end

    // sync mode clocks
    // Both ticks come from the memory clock pin; the memory tick is every
    // other fast tick, so the two stay phase locked.
    // async clock sources
    // The fast tick follows the core clock pin, unrelated to the memory pin.
    wire fast_tick = sync_mode ? pin_rise[1] : pin_rise[2];
    wire mem_tick = sync_mode ? (pin_rise[1] & div_q) : pin_rise[1];

    // Control bits and flush strobe.
    wire cache_en = ctrl_q[`CCWB_CTRL_CACHE];
    wire wbuf_en = ctrl_q[`CCWB_CTRL_WBUF];
    wire flush = reg_wr_in & (reg_addr_in == `CCWB_REG_FLUSH);

    // queue enable bit
    // The control bits reset to zero, so the cache and queue start disabled.
    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            ctrl_q <= `CCWB_CTRL_RST;
            reg_rdata_out <= 32'h0;
        end else if (ce_in) begin
            if (reg_wr_in && reg_addr_in == `CCWB_REG_CTRL) begin
                ctrl_q <= reg_wdata_in[`CCWB_CTRL_W-1:0];
            end
            reg_rdata_out <= 32'h0;
            if (reg_rd_in && reg_addr_in == `CCWB_REG_CTRL) begin
                reg_rdata_out <= {28'h0, ctrl_q};
            end
            if (reg_rd_in && reg_addr_in == `CCWB_REG_STAT) begin
                reg_rdata_out[`CCWB_ST_EMPTY] <= (wq_acnt_q == 3'h0);
                reg_rdata_out[`CCWB_ST_MEMORY_CLOCK_INPUT] <= core_on_mem_clk_out;
                reg_rdata_out[`CCWB_ST_LOCK] <= lock_q;
                reg_rdata_out[`CCWB_ST_SYNC] <= sync_mode;
                reg_rdata_out[`CCWB_ST_DCNT_HI:`CCWB_ST_DCNT_LO] <= wq_dcnt_q;
                reg_rdata_out[`CCWB_ST_ACNT_HI:`CCWB_ST_ACNT_LO] <= wq_acnt_q;
            end
        end
    end

    // Address split of the current core request.
    wire [21:0] cur_tag = core_addr_in[`CCWB_TAG_HI:`CCWB_TAG_LO];
    wire [5:0] cur_set = core_addr_in[`CCWB_SET_HI:`CCWB_SET_LO];
    wire [1:0] cur_wrd = core_addr_in[`CCWB_WRD_HI:`CCWB_WRD_LO];
    wire [3:0] hit_vec;

    // set associative lookup
    // All four ways of the set are compared at once on the virtual tag.
    genvar gw;
    generate
        for (gw = 0; gw < `CCWB_WAYS; gw = gw + 1) begin : g_way
            wire [7:0] line = {cur_set, gw[1:0]};
            assign hit_vec[gw] = valid_q[line] & (tag_q[line] == cur_tag);
        end
    endgenerate

    reg [1:0] hit_way;
    always @* begin
        hit_way = 2'h0;
        if (hit_vec[1]) begin
            hit_way = 2'h1;
        end
        if (hit_vec[2]) begin
            hit_way = 2'h2;
        end
        if (hit_vec[3]) begin
            hit_way = 2'h3;
        end
    end
    wire hit = |hit_vec;
    wire [31:0] hit_word = data_q[{cur_set, hit_way, cur_wrd}];

    // Queue space check; a sequential write joins the newest address slot
    // unless that slot is the one draining, which avoids a length race.
    wire [1:0] wq_last = wq_atail_q - 2'h1;
    wire [31:0] wq_next = wq_addr_q[wq_last] + {26'h0, wq_len_q[wq_last], 2'h0};
    wire wq_merge = core_seq_in & (wq_acnt_q != 3'h0) & (wq_next == core_addr_in)
        & ~(own_q & (wq_last == wq_ahead_q));
    wire wq_space = (wq_dcnt_q < `CCWB_WQ_WORDS) & (wq_merge | (wq_acnt_q < `CCWB_WQ_ADDRS));
    wire wq_empty = (wq_acnt_q == 3'h0);
    wire buffered = wbuf_en & core_bufferable_in & ~core_lock_in;

    // Core request handling, external bus engine, queue and cache storage.
    reg push_d, pop_d, push_a, pop_a;
    always @* begin
        push_d = ce_in & (state_q == S_IDLE) & core_req_in & ~core_ack_out & fast_tick
            & core_wr_in & buffered & wq_space;
        push_a = push_d & ~wq_merge;
        pop_d = ce_in & own_q & ext_ack_in;
        pop_a = pop_d & ({1'b0, wq_idx_q} + 4'h1 == wq_len_q[wq_ahead_q]);
    end

    always @(posedge mclk_in) begin
        if (!resetn_in) begin
            valid_q <= {`CCWB_LINES{1'b0}};
            state_q <= S_IDLE;
            op_q <= OP_SINGLE;
            fill_cnt_q <= 2'h0;
            victim_q <= 2'h0;
            fill_ok_q <= 1'b0;
            lock_q <= 1'b0;
            own_q <= 1'b0;
            lfsr_q <= `CCWB_LFSR_SEED;
            core_ack_out <= 1'b0;
            core_rdata_out <= 32'h0;
            core_on_mem_clk_out <= 1'b0;
            ext_req_out <= 1'b0;
            ext_wr_out <= 1'b0;
            ext_lock_out <= 1'b0;
            ext_addr_out <= 32'h0;
            ext_wdata_out <= 32'h0;
            wq_ahead_q <= 2'h0;
            wq_atail_q <= 2'h0;
            wq_dhead_q <= 3'h0;
            wq_dtail_q <= 3'h0;
            wq_idx_q <= 3'h0;
            wq_dcnt_q <= 4'h0;
            wq_acnt_q <= 3'h0;
        end else if (ce_in) begin
            lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
            core_ack_out <= 1'b0;
            ext_lock_out <= lock_q;
            // fetch overlap allowed
            // The flush takes effect at once, which is stricter than needed.
            if (flush) begin
                valid_q <= {`CCWB_LINES{1'b0}};
                fill_ok_q <= 1'b0;
            end
            // Queue bookkeeping; a push and a pop may land in one cycle.
            if (push_d) begin
                wq_data_q[wq_dtail_q] <= core_wdata_in;
                wq_dtail_q <= wq_dtail_q + 3'h1;
                if (push_a) begin
                    wq_addr_q[wq_atail_q] <= core_addr_in;
                    wq_len_q[wq_atail_q] <= 4'h1;
                    wq_atail_q <= wq_atail_q + 2'h1;
                end else begin
                    wq_len_q[wq_last] <= wq_len_q[wq_last] + 4'h1;
                end
            end
            if (pop_d) begin
                wq_dhead_q <= wq_dhead_q + 3'h1;
                own_q <= 1'b0;
                ext_req_out <= 1'b0;
                if (pop_a) begin
                    wq_ahead_q <= wq_ahead_q + 2'h1;
                    wq_idx_q <= 3'h0;
                end else begin
                    wq_idx_q <= wq_idx_q + 3'h1;
                end
            end
            wq_dcnt_q <= wq_dcnt_q + {3'h0, push_d} - {3'h0, pop_d};
            wq_acnt_q <= wq_acnt_q + {2'h0, push_a} - {2'h0, pop_a};
            // in-order drain
            // The oldest word goes out on a memory tick whenever the bus is idle.
            if (!ext_req_out && !wq_empty && mem_tick && state_q != S_EXT) begin
                ext_req_out <= 1'b1;
                ext_wr_out <= 1'b1;
                own_q <= 1'b1;
                ext_addr_out <= wq_addr_q[wq_ahead_q] + {27'h0, wq_idx_q, 2'h0};
                ext_wdata_out <= wq_data_q[wq_dhead_q];
            end
            case (state_q)
                S_IDLE: begin
                    core_on_mem_clk_out <= 1'b0;
                    if (core_req_in && !core_ack_out && fast_tick) begin
                        fill_cnt_q <= 2'h0;
                        victim_q <= lfsr_q[1:0];
                        if (core_wr_in) begin
                            if (hit && (!buffered || wq_space)) begin
                                data_q[{cur_set, hit_way, cur_wrd}] <= core_wdata_in;
                            end
                            if (buffered) begin
                                core_ack_out <= wq_space;
                            end else begin
                                op_q <= OP_UNBUF;
                                state_q <= S_TOMEM;
                            end
                        end else if (cache_en && hit && !core_lock_in) begin
                            core_rdata_out <= hit_word;
                            core_ack_out <= 1'b1;
                        end else begin
                            op_q <= (cache_en && core_cacheable_in && !core_lock_in)
                                ? OP_FILL : OP_SINGLE;
                            fill_ok_q <= 1'b1;
                            lock_q <= core_lock_in;
                            state_q <= S_TOMEM;
                        end
                    end
                end
                S_TOMEM: begin
                    core_on_mem_clk_out <= 1'b1;
                    if (wq_empty && !ext_req_out && mem_tick) begin
                        ext_req_out <= 1'b1;
                        ext_wr_out <= (op_q == OP_UNBUF);
                        ext_wdata_out <= core_wdata_in;
                        if (op_q == OP_FILL) begin
                            ext_addr_out <= {core_addr_in[31:4], fill_cnt_q, 2'h0};
                        end else begin
                            ext_addr_out <= core_addr_in;
                        end
                        state_q <= S_EXT;
                    end
                end
                S_EXT: begin
                    if (ext_ack_in) begin
                        ext_req_out <= 1'b0;
                        state_q <= S_TOFAST;
                        if (op_q == OP_FILL) begin
                            data_q[{cur_set, victim_q, fill_cnt_q}] <= ext_rdata_in;
                            if (fill_cnt_q == cur_wrd) begin
                                core_rdata_out <= ext_rdata_in;
                            end
                            if (fill_cnt_q == `CCWB_LINE_LAST) begin
                                tag_q[{cur_set, victim_q}] <= cur_tag;
                                valid_q[{cur_set, victim_q}] <= fill_ok_q & ~flush;
                            end else begin
                                fill_cnt_q <= fill_cnt_q + 2'h1;
                                state_q <= S_TOMEM;
                            end
                        end else if (op_q == OP_SINGLE) begin
                            core_rdata_out <= ext_rdata_in;
                        end else begin
                            lock_q <= 1'b0;
                        end
                    end
                end
                S_TOFAST: begin
                    if (fast_tick) begin
                        core_ack_out <= 1'b1;
                        core_on_mem_clk_out <= 1'b0;
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ---- ccwb_checker.sv ----
// Port-level assertions for the cache and posted write queue block.
`timescale 1ns/1ps
`default_nettype none
module ccwb_checker (
    // Clock and reset.
    input wire mclk_in,
    input wire resetn_in,
    input wire ce_in,
    // Register read port.
    input wire reg_rd_in,
    input wire [31:0] reg_rdata_out,
    // Core side.
    input wire core_wr_in,
    input wire core_lock_in,
    input wire core_cacheable_in,
    input wire core_ack_out,
    input wire core_on_mem_clk_out,
    // Memory bus side.
    input wire ext_req_out,
    input wire ext_wr_out,
    input wire ext_lock_out,
    input wire [31:0] ext_addr_out,
    input wire [31:0] ext_wdata_out,
    input wire ext_ack_in
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    reg [2:0] nrd_q;
    reg wseen_q;
    // External reads and locked writes seen since the last core answer.
    always @(posedge mclk_in) begin
        if (!resetn_in || core_ack_out) begin
            nrd_q <= 3'h0;
            wseen_q <= 1'b0;
        end else begin
            nrd_q <= nrd_q + {2'h0, ext_req_out && ext_ack_in && !ext_wr_out};
            wseen_q <= wseen_q | (ext_req_out && ext_ack_in && ext_wr_out && ext_lock_out);
        end
    end
    property p_reset_quiet;
        disable iff (1'b0) !resetn_in |=> !core_ack_out && !ext_req_out && !ext_lock_out;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("active after reset");
    property p_ext_hold;
        ext_req_out && !ext_ack_in |=> ext_req_out
            && $stable({ext_wr_out, ext_addr_out, ext_wdata_out});
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("bus request not held");
    property p_lock_read;
        core_ack_out && core_lock_in && !core_wr_in |-> nrd_q == 3'h1;
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("locked read not external");
    property p_lock_span;
        core_ack_out && core_lock_in && !core_wr_in |-> ext_lock_out;
    endproperty
    a_lock_span: assert property (p_lock_span) else $error("lock low in swap");
    property p_lock_wr;
        core_ack_out && core_wr_in && core_lock_in |-> wseen_q;
    endproperty
    a_lock_wr: assert property (p_lock_wr) else $error("locked write not done");
    property p_whole_line;
        core_ack_out && !core_wr_in && core_cacheable_in |-> nrd_q != 3'h2 && nrd_q != 3'h3;
    endproperty
    a_whole_line: assert property (p_whole_line) else $error("partial line fill");
    property p_uncached;
        core_ack_out && !core_wr_in && !core_cacheable_in |-> nrd_q <= 3'h1;
    endproperty
    a_uncached: assert property (p_uncached) else $error("uncached read filled");
    property p_mem_clk;
        ext_req_out && !ext_wr_out |-> core_on_mem_clk_out;
    endproperty
    a_mem_clk: assert property (p_mem_clk) else $error("read on fast clock");
    property p_rdata_idle;
        ce_in && !reg_rd_in |=> reg_rdata_out == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
endmodule
`default_nettype wire

// ---- ccwb_mem_model.sv ----
// Behavioural external memory answering the block's memory bus.
`timescale 1ns/1ps
`default_nettype none
module ccwb_mem_model (
    // Clock, reset and answer delay.
    input wire mclk_in,
    input wire resetn_in,
    input wire [7:0] delay_in,
    // Memory bus, named as on the block.
    input wire ext_req_out,
    input wire ext_wr_out,
    input wire [31:0] ext_addr_out,
    input wire [31:0] ext_wdata_out,
    output reg ext_ack_in,
    output reg [31:0] ext_rdata_in
);
    reg [31:0] mem_q [0:255];
    reg [7:0] wait_q;
    integer i;
    // Contents start from a pattern the bench can predict.
    initial begin
        for (i = 0; i < 256; i = i + 1) mem_q[i] = 32'hC0DE0000 | i;
        ext_ack_in = 1'b0;
        ext_rdata_in = 32'h0;
        wait_q = 8'h0;
    end
    // Answer after the delay; between answers the data bus toggles so stale data shows.
    always @(posedge mclk_in) begin
        ext_ack_in <= 1'b0;
        ext_rdata_in <= ~ext_rdata_in;
        if (!resetn_in || !ext_req_out || ext_ack_in) begin
            wait_q <= 8'h0;
        end else if (wait_q >= delay_in) begin
            ext_ack_in <= 1'b1;
            ext_rdata_in <= mem_q[ext_addr_out[9:2]];
            if (ext_wr_out) mem_q[ext_addr_out[9:2]] <= ext_wdata_out;
        end else begin
            wait_q <= wait_q + 8'h1;
        end
    end
endmodule
`default_nettype wire

// ---- tb_ccwb_top.sv ----
// Self-checking bench for the cache and posted write queue block.
`timescale 1ns/1ps
`default_nettype none
module tb_ccwb_top;
    logic mclk_in, resetn_in, ce_in, sync_async_select_in;
    logic memory_clock_input_in, core_clock_input_in, reg_wr_in, reg_rd_in;
    logic [2:0] reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, core_addr_in, core_wdata_in, core_rdata_out;
    logic core_req_in, core_wr_in, core_lock_in, core_seq_in, core_cacheable_in;
    logic core_bufferable_in, core_ack_out, core_on_mem_clk_out, ext_req_out, ext_wr_out;
    logic ext_lock_out, ext_ack_in, rd_seen;
    logic [31:0] ext_addr_out, ext_wdata_out, ext_rdata_in, rng;
    logic [7:0] delay_q;
    logic [31:0] sh [0:255];
    logic [63:0] exp_reg[$], exp_core[$], exp_wr[$];
    logic [63:0] reg_note;
    int fails = 0;
    int samples_checked = 0;
    int ext_rd_cnt = 0;
    int pc = 0;
    ccwb_top ccwb_top_i (.mclk_in, .resetn_in, .ce_in, .sync_async_select_in,
        .memory_clock_input_in, .core_clock_input_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .core_req_in, .core_wr_in, .core_lock_in,
        .core_seq_in, .core_cacheable_in, .core_bufferable_in, .core_addr_in, .core_wdata_in,
        .core_ack_out, .core_rdata_out, .core_on_mem_clk_out, .ext_req_out, .ext_wr_out,
        .ext_lock_out, .ext_addr_out, .ext_wdata_out, .ext_ack_in, .ext_rdata_in);
    ccwb_mem_model ccwb_mem_model_i (.mclk_in, .resetn_in, .delay_in(delay_q), .ext_req_out,
        .ext_wr_out, .ext_addr_out, .ext_wdata_out, .ext_ack_in, .ext_rdata_in);
    initial begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end
    // Slow clock pins, far below the system clock so the input filter sees every level.
    always @(posedge mclk_in) begin
        pc <= pc + 1;
        memory_clock_input_in <= (pc % 6) < 3;
        core_clock_input_in <= pc[1];
    end
    function automatic logic [31:0] nxt();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    task automatic chk(input string nm, input logic [63:0] e, g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict;
        if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic rst;
        resetn_in <= 1'b0;
        repeat (10) @(posedge mclk_in);
        resetn_in <= 1'b1;
        repeat (6) @(posedge mclk_in);
    endtask
    task automatic rw(input logic [2:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rr(input logic [2:0] a, input logic [31:0] m, e);
        exp_reg.push_back({m, e});
        @(posedge mclk_in);
        {reg_addr_in, reg_rd_in} <= {a, 1'b1};
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
    endtask
    // One core access; a negative read count skips the external read tally.
    task automatic op(input logic w, k, s, c, b, input logic [31:0] a, input int nrd,
                      output int lat);
        int c0;
        logic [31:0] d;
        c0 = ext_rd_cnt;
        lat = 0;
        d = nxt();
        if (w) begin
            exp_wr.push_back({a, d});
            sh[a[9:2]] = d;
        end else exp_core.push_back({32'h0, sh[a[9:2]]});
        @(posedge mclk_in);
        {core_wr_in, core_lock_in, core_seq_in, core_cacheable_in} <= {w, k, s, c};
        {core_bufferable_in, core_addr_in, core_wdata_in, core_req_in} <= {b, a, d, 1'b1};
        do begin
            @(negedge mclk_in);
            lat++;
        end while (!core_ack_out && lat < 3000);
        if (core_ack_out !== 1'b1) begin
            fails++;
            print_verdict;
        end
        @(posedge mclk_in);
        core_req_in <= 1'b0;
        if (nrd >= 0) chk("ext_reads", nrd, ext_rd_cnt - c0);
    endtask
    task automatic drain;
        int n;
        n = 0;
        while (exp_wr.size() != 0 && n < 3000) begin
            @(posedge mclk_in);
            n++;
        end
        chk("queue_left", 0, exp_wr.size());
    endtask
    // Results are taken off the notes in arrival order, mid-cycle where they are settled.
    always @(negedge mclk_in) begin
        // The note is taken off once, so expected value and mask come from the same entry.
        if (rd_seen) begin
            reg_note = exp_reg.pop_front();
            chk("reg_rdata", reg_note[31:0], reg_rdata_out & reg_note[63:32]);
        end
        rd_seen = reg_rd_in;
        if (core_ack_out && !core_wr_in) begin
            chk("core_rdata", exp_core.pop_front(), core_rdata_out);
        end
        if (ext_req_out && ext_ack_in && !ext_wr_out) ext_rd_cnt++;
        if (ext_req_out && ext_ack_in && ext_wr_out) begin
            chk("ext_write", exp_wr.pop_front(), {ext_addr_out, ext_wdata_out});
        end
    end
    initial begin
        int r, i, lat;
        {reg_wr_in, reg_rd_in, core_req_in, core_wr_in, core_lock_in, core_seq_in} = 6'h0;
        {core_cacheable_in, core_bufferable_in, memory_clock_input_in} = 3'h0;
        {reg_addr_in, reg_wdata_in, core_addr_in, core_wdata_in} = 99'h0;
        {ce_in, sync_async_select_in, core_clock_input_in, resetn_in, rd_seen} = 5'h18;
        delay_q = 8'h2;
        rng = 32'h3EC9A633;
        for (i = 0; i < 256; i++) sh[i] = 32'hC0DE0000 | i;
        rst;
        rr(3'h2, 32'h7FF, 32'h9);
        rr(3'h1, 32'hF, 32'h0);
        rr(3'h5, 32'hFFFFFFFF, 32'h0);
        rw(3'h1, 32'h5);
        rr(3'h1, 32'hF, 32'h5);
        op(0, 0, 0, 0, 0, 32'h100, 1, lat);
        op(0, 0, 0, 0, 0, 32'h100, 1, lat);
        op(0, 0, 0, 1, 0, 32'h108, 4, lat);
        op(0, 0, 0, 1, 0, 32'h10C, 0, lat);
        op(0, 0, 0, 0, 0, 32'h100, 0, lat);
        rw(3'h1, 32'hD);
        op(0, 1, 0, 1, 1, 32'h104, 1, lat);
        op(1, 1, 0, 1, 1, 32'h104, -1, lat);
        chk("queue_left", 0, exp_wr.size());
        op(0, 0, 0, 1, 0, 32'h104, 0, lat);
        rw(3'h7, 32'h0);
        op(0, 0, 0, 1, 0, 32'h104, 4, lat);
        delay_q <= 8'hC8;
        // Address slots run out first, then data slots of a sequential run.
        for (r = 0; r < 2; r++) begin
            for (i = 0; i < 5 + 4 * r; i++) begin
                op(1, 0, r && i > 2, 0, 1, 32'h200 + 4 * i, -1, lat);
                chk("write_fast", i < 4 + 4 * r, lat < 12);
            end
            drain;
        end
        delay_q <= 8'h14;
        op(1, 0, 0, 0, 1, 32'h2F0, -1, lat);
        chk("queue_busy", 1, exp_wr.size() != 0);
        op(1, 0, 0, 0, 0, 32'h300, -1, lat);
        chk("queue_left", 0, exp_wr.size());
        rw(3'h1, 32'h5);
        op(1, 0, 0, 0, 1, 32'h304, -1, lat);
        chk("queue_left", 0, exp_wr.size());
        sync_async_select_in <= 1'b0;
        repeat (8) @(posedge mclk_in);
        rr(3'h2, 32'h8, 32'h0);
        op(0, 0, 0, 1, 0, 32'h104, 0, lat);
        op(0, 0, 0, 0, 0, 32'h300, 1, lat);
        sync_async_select_in <= 1'b1;
        rw(3'h1, 32'h1);
        rw(3'h7, 32'h0);
        op(0, 0, 0, 1, 0, 32'h104, -1, lat);
        rw(3'h1, 32'h5);
        op(0, 0, 0, 1, 0, 32'h100, 4, lat);
        rst;
        rr(3'h1, 32'hF, 32'h0);
        rw(3'h1, 32'h5);
        op(0, 0, 0, 1, 0, 32'h100, 4, lat);
        print_verdict;
    end
endmodule
bind ccwb_top ccwb_checker ccwb_checker_i (.mclk_in, .resetn_in, .ce_in, .reg_rd_in,
    .reg_rdata_out, .core_wr_in,
    .core_lock_in, .core_cacheable_in, .core_ack_out, .core_on_mem_clk_out, .ext_req_out,
    .ext_wr_out, .ext_lock_out, .ext_addr_out, .ext_wdata_out, .ext_ack_in);
`default_nettype wire
